//--- hw/prom_prog_defines.vh
// Constants for the PROM programmer controller.
// Assumes a 125 MHz system clock and a device whose data pins are two-way.
`ifndef PROM_PROG_DEFINES_VH
`define PROM_PROG_DEFINES_VH
`define CLK_PERIOD_NS 8
`define PULSE_US 100
`define PULSE_CYC ((`PULSE_US * 1000) / `CLK_PERIOD_NS)
`define SETUP_NS 100
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAX_TRIES 4'ha
`define PAGE_BYTES 3'h4
`define LAST_ADDR_BIG 17'h0efff
`define LAST_ADDR_SMALL 17'h07fff
`define ERASED_BYTE 8'hff
`endif

//--- hw/prom_prog_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module prom_prog_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_r;
   reg [AW-1:0] rd_r;
   reg [AW:0] cnt_r;
   reg [AW:0] cnt_nxt;
   reg rdy_r;
   wire push;
   wire pop;
   // Ready comes from a flop so that the upstream port sees no comparator delay.
   assign in_ready = rdy_r;
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data = mem[rd_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always @* begin
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end
   always @(posedge sys_clk) begin
      if (push) begin
         mem[wr_r] <= in_data;
      end
      if (sys_rst) begin
         wr_r <= {AW{1'b0}};
         rd_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
         rdy_r <= 1'b1;
      end else begin
         if (push) begin
            wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
         end
         cnt_r <= cnt_nxt;
         rdy_r <= (cnt_nxt != DEPTH[AW:0]);
      end
   end
endmodule

//--- hw/prom_prog_host.v
// PROM programmer: drives address, data and strobes of a device in programming mode.
// Assumes the device is already held in reset, with the programming supply raised only while vpp_write_r is high,
// and that supply sequencing is handled by external hardware steered by vpp_write_r.
`timescale 1ns/1ps
`include "prom_prog_defines.vh"
module prom_prog_host #(
   parameter PULSE_CYC = `PULSE_CYC,
   parameter DEPTH = 8
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire start,
   input wire big_part,
   input wire byte_mode,
   input wire [16:0] start_addr,
   input wire [16:0] last_addr,
   input wire [7:0] wr_data,
   input wire wr_valid,
   output wire wr_ready,
   input wire [7:0] dev_data_in,
   output reg [7:0] dev_data_out_r,
   output reg dev_data_oe_r,
   output reg [16:0] address_bus_lines_r,
   output reg chip_enable_n_r,
   output reg output_gate_n_r,
   output reg program_strobe_n_r,
   output reg vpp_write_r,
   output reg busy_r,
   output reg done_r,
   output reg fail_r
);
   localparam S_IDLE = 4'h0;
   localparam S_LATCH = 4'h1;
   localparam S_PULSE = 4'h2;
   localparam S_VER = 4'h3;
   localparam S_NEXT = 4'h4;
   localparam S_FINAL = 4'h5;
   localparam S_END = 4'h6;
   localparam S_LOAD = 4'h7;

   wire [7:0] f_data;
   wire f_valid;
   reg f_pop;
   reg [3:0] st_r;
   reg [31:0] tmr_r;
   reg [3:0] tries_r;
   reg [2:0] idx_r;
   reg [16:0] base_r;
   reg [16:0] end_r;
   reg mode_r;
   reg [7:0] page_r [0:3];
   reg [7:0] img_r [0:255];
   wire [16:0] cap;
   wire [16:0] cur;

   prom_prog_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(3)) u_fifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .in_data(wr_data),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .out_data(f_data),
      .out_valid(f_valid),
      .out_ready(f_pop)
   );

   assign cap = big_part ? `LAST_ADDR_BIG : `LAST_ADDR_SMALL;
   assign cur = base_r + {14'h0000, idx_r};

   always @* begin
      f_pop = (st_r == S_LOAD) && f_valid;
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // The page buffer is filled from the FIFO first, so the strobes never wait mid-page.
   always @(posedge sys_clk) begin
      if (f_pop) begin
         page_r[idx_r[1:0]] <= f_data;
         img_r[cur[7:0]] <= f_data;
      end
      if (sys_rst) begin
         st_r <= S_IDLE;
         tmr_r <= 32'h0;
         tries_r <= 4'h0;
         idx_r <= 3'h0;
         base_r <= 17'h0;
         end_r <= 17'h0;
         mode_r <= 1'b0;
         dev_data_out_r <= 8'h00;
         dev_data_oe_r <= 1'b0;
         address_bus_lines_r <= 17'h0;
         chip_enable_n_r <= 1'b1;
         output_gate_n_r <= 1'b1;
         program_strobe_n_r <= 1'b1;
         vpp_write_r <= 1'b0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         fail_r <= 1'b0;
      end else begin
         case (st_r)
            S_IDLE: begin
               chip_enable_n_r <= 1'b1;
               output_gate_n_r <= 1'b1;
               program_strobe_n_r <= 1'b1;
               dev_data_oe_r <= 1'b0;
               if (start) begin
                  base_r <= start_addr;
                  end_r <= (last_addr > cap) ? cap : last_addr;
                  mode_r <= byte_mode;
                  idx_r <= 3'h0;
                  tries_r <= 4'h0;
                  busy_r <= 1'b1;
                  done_r <= 1'b0;
                  fail_r <= 1'b0;
                  vpp_write_r <= 1'b1;
                  st_r <= S_LOAD;
               end
            end
            S_LOAD: begin
               if (f_valid) begin
                  if (mode_r || idx_r == `PAGE_BYTES - 3'h1 || cur == end_r) begin
                     idx_r <= 3'h0;
                     tmr_r <= 32'h0;
                     st_r <= S_LATCH;
                  end else begin
                     idx_r <= idx_r + 3'h1;
                  end
               end
            end
            S_LATCH: begin
               address_bus_lines_r <= cur;
               dev_data_out_r <= page_r[idx_r[1:0]];
               dev_data_oe_r <= 1'b1;
               chip_enable_n_r <= mode_r ? 1'b0 : 1'b1;
               program_strobe_n_r <= 1'b1;
               output_gate_n_r <= mode_r ? 1'b1 : 1'b0;
               tmr_r <= tmr_r + 32'h1;
               if (tmr_r == `SETUP_CYC) begin
                  tmr_r <= 32'h0;
                  if (mode_r || idx_r == `PAGE_BYTES - 3'h1 || cur == end_r) begin
                     output_gate_n_r <= 1'b1;
                     st_r <= S_PULSE;
                  end else begin
                     idx_r <= idx_r + 3'h1;
                  end
               end
            end
            S_PULSE: begin
               output_gate_n_r <= 1'b1;
               chip_enable_n_r <= mode_r ? 1'b0 : 1'b1;
               program_strobe_n_r <= 1'b0;
               tmr_r <= tmr_r + 32'h1;
               // The strobe fell at the edge where the timer read zero, so it must rise
               // at the edge where the timer reads PULSE_CYC to stay low that many clocks.
               if (tmr_r == PULSE_CYC) begin
                  program_strobe_n_r <= 1'b1;
                  dev_data_oe_r <= 1'b0;
                  tries_r <= tries_r + 4'h1;
                  tmr_r <= 32'h0;
                  if (!mode_r) begin
                     idx_r <= 3'h0;
                  end
                  st_r <= S_VER;
               end
            end
            S_VER: begin
               address_bus_lines_r <= cur;
               chip_enable_n_r <= 1'b0;
               output_gate_n_r <= 1'b0;
               dev_data_oe_r <= 1'b0;
               tmr_r <= tmr_r + 32'h1;
               if (tmr_r == `SETUP_CYC) begin
                  tmr_r <= 32'h0;
                  output_gate_n_r <= 1'b1;
                  if (dev_data_in != page_r[idx_r[1:0]]) begin
                     if (tries_r == `MAX_TRIES) begin
                        fail_r <= 1'b1;
                        st_r <= S_END;
                     end else begin
                        idx_r <= mode_r ? idx_r : 3'h0;
                        st_r <= S_LATCH;
                     end
                  end else if (mode_r || idx_r == `PAGE_BYTES - 3'h1 || cur == end_r) begin
                     st_r <= S_NEXT;
                  end else begin
                     idx_r <= idx_r + 3'h1;
                  end
               end
            end
            S_NEXT: begin
               chip_enable_n_r <= 1'b1;
               tries_r <= 4'h0;
               if (cur >= end_r) begin
                  vpp_write_r <= 1'b0;
                  base_r <= start_addr;
                  idx_r <= 3'h0;
                  st_r <= S_FINAL;
               end else begin
                  base_r <= cur + 17'h1;
                  idx_r <= 3'h0;
                  st_r <= S_LOAD;
               end
            end
            S_FINAL: begin
               // read mode, chip enable and gate low
               address_bus_lines_r <= base_r;
               chip_enable_n_r <= 1'b0;
               output_gate_n_r <= 1'b0;
               tmr_r <= tmr_r + 32'h1;
               if (tmr_r == `SETUP_CYC) begin
                  tmr_r <= 32'h0;
                  if (dev_data_in != img_r[base_r[7:0]]) begin
                     fail_r <= 1'b1;
                     st_r <= S_END;
                  end else if (base_r >= end_r) begin
                     st_r <= S_END;
                  end else begin
                     base_r <= base_r + 17'h1;
                  end
               end
            end
            S_END: begin
               chip_enable_n_r <= 1'b1;
               output_gate_n_r <= 1'b1;
               program_strobe_n_r <= 1'b1;
               dev_data_oe_r <= 1'b0;
               vpp_write_r <= 1'b0;
               busy_r <= 1'b0;
               done_r <= 1'b1;
               st_r <= S_IDLE;
            end
            default: begin
               st_r <= S_IDLE;
            end
         endcase
      end
   end
endmodule

//--- test/prom_prog_host_monitor.sv
// Port checker for the PROM programmer.
// Assumes it is bound into every prom_prog_host instance.
`timescale 1ns/1ps
module prom_prog_host_monitor #(
   parameter PULSE_CYC = 20
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire big_part,
   input wire dev_data_oe_r,
   input wire [16:0] address_bus_lines_r,
   input wire chip_enable_n_r,
   input wire output_gate_n_r,
   input wire program_strobe_n_r,
   input wire vpp_write_r,
   input wire done_r,
   input wire fail_r
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // Strobe timing and modes
   // ----------------------------------------
   logic [15:0] low_cnt_r;
   always @(posedge sys_clk) begin
      low_cnt_r <= program_strobe_n_r ? 16'h0 : low_cnt_r + 16'h1;
   end
   pulse_len_a: assert property ($rose(program_strobe_n_r) |-> low_cnt_r == PULSE_CYC)
      else $error("program pulse has the wrong length");
   pulse_gate_a: assert property (!program_strobe_n_r |-> output_gate_n_r)
      else $error("gate low during program pulse");
   pulse_supply_a: assert property (!program_strobe_n_r |-> vpp_write_r)
      else $error("program pulse without programming supply");
   pulse_addr_a: assert property (!program_strobe_n_r [*2] |-> $stable(address_bus_lines_r))
      else $error("address moved during program pulse");
   no_fight_a: assert property (dev_data_oe_r |-> chip_enable_n_r || output_gate_n_r)
      else $error("host drives data while device may drive");
   latch_drive_a: assert property (chip_enable_n_r && !output_gate_n_r
      |-> dev_data_oe_r && program_strobe_n_r)
      else $error("page latch without data or with strobe low");
   read_float_a: assert property (!chip_enable_n_r && !output_gate_n_r
      |-> !dev_data_oe_r && program_strobe_n_r)
      else $error("verify or read with host driving or strobe low");
   addr_range_a: assert property (!program_strobe_n_r
      |-> address_bus_lines_r <= (big_part ? 17'h0efff : 17'h07fff))
      else $error("write outside the part range");
   fail_done_a: assert property ($rose(fail_r) |=> done_r)
      else $error("failure raised without done");
   cover property ($fell(program_strobe_n_r) && chip_enable_n_r);
   cover property ($fell(program_strobe_n_r) && !chip_enable_n_r);
   cover property ($rose(fail_r));
endmodule
bind prom_prog_host prom_prog_host_monitor #(.PULSE_CYC(PULSE_CYC)) i_mon (.sys_clk, .sys_rst,
   .big_part, .dev_data_oe_r, .address_bus_lines_r, .chip_enable_n_r, .output_gate_n_r,
   .program_strobe_n_r, .vpp_write_r, .done_r, .fail_r);

//--- test/prom_dev_model.sv
// Behavioural device in programming mode: 256-byte array and a four-entry page latch.
// Assumes pin levels are sampled on the host clock; stuck refuses every write.
`timescale 1ns/1ps
module prom_dev_model (
   input wire sys_clk,
   input wire [16:0] addr,
   input wire ce_n,
   input wire oe_n,
   input wire pgm_n,
   input wire vpp_hi,
   input wire [7:0] din,
   input wire stuck,
   output logic [7:0] dout
);
   logic [7:0] mem [0:255];
   logic [7:0] lat [0:3];
   logic [7:0] lat_a [0:3];
   logic [3:0] lv = 4'h0;
   logic pgm_d = 1'b1;
   logic wrote = 1'b0;
   logic [7:0] last = 8'h00;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'hff;
   end
   always @(posedge sys_clk) begin
      pgm_d <= pgm_n;
      if (ce_n && !oe_n && pgm_n) begin
         lat[addr[1:0]] <= din;
         lat_a[addr[1:0]] <= addr[7:0];
         lv <= (wrote ? 4'h0 : lv) | (4'h1 << addr[1:0]);
         wrote <= 1'b0;
      end
      if (pgm_d && !pgm_n && oe_n && vpp_hi && !stuck) begin
         if (!ce_n) mem[addr[7:0]] <= din;
         else for (int i = 0; i < 4; i++) if (lv[i]) mem[lat_a[i]] <= lat[i];
         wrote <= 1'b1;
      end
      if (!ce_n && !oe_n) last <= mem[addr[7:0]];
   end
   assign dout = (!ce_n && !oe_n) ? mem[addr[7:0]] : ~last;
endmodule

//--- test/prom_prog_host_bench.sv
// Bench for the PROM programmer: random page and byte jobs against the device model.
// Assumes the design under hw/ and the model and checker under test/.
`timescale 1ns/1ps
module prom_prog_host_bench;
   logic sys_clk = 0, sys_rst = 1, start = 0, big_part = 1, byte_mode = 0;
   logic wr_valid = 0, stuck = 0;
   logic [16:0] start_addr = 0, last_addr = 0;
   logic [7:0] wr_data = 0;
   logic [7:0] exp_img [0:255];
   wire wr_ready, oe, ce_n, og_n, pgm_n, vpp, busy, done, fail;
   wire [7:0] dq, dout, dev_out;
   wire [16:0] adr;
   int num_errors = 0, num_checks = 0, cyc = 0, pulses = 0, n, b, k;
   integer seed = 32'h709771a5;
   always #4 sys_clk = ~sys_clk;
   assign dq = oe ? dev_out : dout;
   prom_prog_host #(.PULSE_CYC(20)) i_dut (.sys_clk, .sys_rst, .start, .big_part,
      .byte_mode, .start_addr, .last_addr, .wr_data, .wr_valid, .wr_ready,
      .dev_data_in(dq), .dev_data_out_r(dev_out), .dev_data_oe_r(oe),
      .address_bus_lines_r(adr), .chip_enable_n_r(ce_n), .output_gate_n_r(og_n),
      .program_strobe_n_r(pgm_n), .vpp_write_r(vpp), .busy_r(busy), .done_r(done),
      .fail_r(fail));
   prom_dev_model i_dev (.sys_clk, .addr(adr), .ce_n, .oe_n(og_n), .pgm_n,
      .vpp_hi(vpp), .din(dq), .stuck, .dout);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         num_errors++;
         wrap_up();
      end
   end
   always @(negedge pgm_n) pulses++;
   task automatic push(input logic [7:0] d);
      wr_data = d;
      wr_valid = 1;
      while (!wr_ready) @(negedge sys_clk);
      @(negedge sys_clk);
   endtask
   // ----------------------------------------
   // One job: pre bytes queued before start
   // ----------------------------------------
   task automatic job(input logic bm, input int base, input int cnt, input int pre);
      logic [7:0] d [$];
      byte_mode = bm;
      big_part = ~big_part;
      start_addr = 17'(base);
      last_addr = 17'(base + cnt - 1);
      // A refused write must differ from what the array holds, or verify would pass.
      for (int i = 0; i < cnt; i++) d.push_back(stuck ? ~exp_img[base + i] : 8'($random(seed)));
      for (int i = 0; i < pre; i++) push(d[i]);
      wr_valid = 0;
      if (pre == 8) check(wr_ready, 0);
      pulses = 0;
      start = 1;
      @(negedge sys_clk);
      start = 0;
      check(busy, 1);
      check(vpp, 1);
      for (int i = pre; i < cnt; i++) push(d[i]);
      wr_valid = 0;
      while (!done) @(negedge sys_clk);
      check(fail, stuck);
      check(busy, 0);
      check(vpp, 0);
      if (stuck) check(pulses, 10);
      for (int i = 0; i < cnt; i++) if (!stuck) exp_img[base + i] = d[i];
      for (k = 0; k < 256; k++) check(i_dev.mem[k], exp_img[k]);
   endtask
   initial begin
      for (k = 0; k < 256; k++) exp_img[k] = 8'hff;
      repeat (8) @(negedge sys_clk);
      sys_rst = 0;
      job(0, 8'h40, 12, 8);
      job(0, 8'hc2, 5, 0);
      job(1, 8'h10, 3, 1);
      for (int j = 0; j < 6; j++) begin
         n = 1 + {$random(seed)} % 8;
         b = {$random(seed)} % (257 - n);
         job(j[0], b, n, {$random(seed)} % (n + 1));
      end
      stuck = 1;
      job(0, 8'h20, 1, 0);
      job(1, 8'h30, 1, 1);
      wrap_up();
   end
endmodule
